// ==== vec_fp_pkg.sv ====
// constants and types shared by the vector floating-point exception unit
package vec_fp_pkg;

   localparam int ADDR_W = 4;
   localparam logic [3:0] ADDR_CTRL_STAT = 4'h0;
   localparam logic [3:0] ADDR_CTRL4 = 4'h4;

   localparam int NUM_EXC = 6;
   localparam int INVALID_BIT = 0;
   localparam int DENORMAL_BIT = 1;
   localparam int DIV_ZERO_BIT = 2;
   localparam int OVERFLOW_BIT = 3;
   localparam int UNDERFLOW_BIT = 4;
   localparam int INEXACT_BIT = 5;
   localparam int MASK_LSB = 7;
   localparam int OS_SUPPORT_BIT = 10;

   localparam logic [15:0] CSR_RESET = 16'h1F80;
   localparam logic [15:0] CSR_WMASK = 16'h1FBF;
   localparam logic CTRL4_RESET = 1'b0;

   localparam int QUIET_BIT_S = 22;
   localparam int QUIET_BIT_D = 51;
   localparam logic [31:0] QNAN_INDEF_S = 32'hFFC00000;
   localparam logic [63:0] QNAN_INDEF_D = 64'hFFF8000000000000;
   localparam logic [31:0] INT_INDEF = 32'h80000000;
   localparam logic [2:0] FLAGS_UNORDERED = 3'h7;

   localparam logic [2:0] PRED_LT = 3'h1;
   localparam logic [2:0] PRED_LE = 3'h2;
   localparam logic [2:0] PRED_UNORD = 3'h3;
   localparam logic [2:0] PRED_NEQ = 3'h4;
   localparam logic [2:0] PRED_NLT = 3'h5;
   localparam logic [2:0] PRED_NLE = 3'h6;

   typedef enum logic [3:0] {
      OP_NONE, OP_INT, OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_SQRT, OP_MAX, OP_MIN,
      OP_CMP, OP_COMI, OP_CVT_FP, OP_CVT_INT, OP_X87_TRUNC
   } op_t;

endpackage

// ==== fp_class_if.sv ====
// operand classification bundle between classifier and exception unit
`timescale 1ns/1ns
interface fp_class_if;
   logic nan;
   logic snan;
   logic inf;
   logic zero;
   logic denorm;
   logic sign;
   modport src (output nan, output snan, output inf, output zero, output denorm, output sign);
   modport dst (input nan, input snan, input inf, input zero, input denorm, input sign);
endinterface

// ==== fp_classify.sv ====
// classifies one single or double precision operand
`timescale 1ns/1ns
module fp_classify (
   input wire logic [63:0] value,
   input wire logic dbl,
   fp_class_if.src cls
);
   logic exp_ones;
   logic exp_zero;
   logic man_zero;
   logic quiet;

   always_comb begin
      if (dbl) begin
         exp_ones = &value[62:52];
         exp_zero = ~|value[62:52];
         man_zero = ~|value[51:0];
         quiet = value[vec_fp_pkg::QUIET_BIT_D];
         cls.sign = value[63];
      end else begin
         exp_ones = &value[30:23];
         exp_zero = ~|value[30:23];
         man_zero = ~|value[22:0];
         quiet = value[vec_fp_pkg::QUIET_BIT_S];
         cls.sign = value[31];
      end
   end

   assign cls.nan = exp_ones & ~man_zero;
   assign cls.snan = exp_ones & ~man_zero & ~quiet;
   assign cls.inf = exp_ones & man_zero;
   assign cls.zero = exp_zero & man_zero;
   assign cls.denorm = exp_zero & ~man_zero;
endmodule

// ==== simd_fp_exception_unit.sv ====
// vector floating-point exception detection, masking and fault selection
//
// Summary of operation
// - six exception classes, each with its own flag and mask bit
// - packed integer operations never raise numeric exceptions
// - faults are reported with the completing instruction, never a later one
// - invalid flag is bit 0, invalid mask is bit 7
// - unmasked exception with os support bit 10 set raises the vector fault
// - os support bit clear: unmasked exception raises undefined-opcode fault instead
// - masked invalid default value overwrites the destination register
// - masked invalid arithmetic with signalling NaN returns that NaN quieted
// - masked invalid square root of signalling NaN returns it quieted
// - masked square root of negative nonzero returns the quiet indefinite
// - masked max/min with any NaN returns the second source
// - compare with NaN gives zeros, ones for neq/unord/nlt/nle
// - precision conversion of signalling NaN returns it quieted
// - flag-writing scalar compare with any NaN sets unordered flags
// - invalid infinity and zero combinations return the quiet indefinite
// - masks written and flags/masks read only through the control register port
// - truncating x87 integer store never raises vector exceptions
// - non-numeric faults pass through like general-purpose instruction faults
// - masked conversion to integer of NaN/infinity/out-of-range gives integer indefinite
// - unmasked invalid leaves the destination unchanged and faults
// - pre-computation conditions first, post-computation only if none unmasked
// - denormal flag is bit 1, denormal mask is bit 8
`timescale 1ns/1ns
module simd_fp_exception_unit #(
   parameter int TAG_W = 6
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [vec_fp_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic op_valid,
   input wire vec_fp_pkg::op_t op_kind,
   input wire logic op_double,
   input wire logic [2:0] op_pred,
   input wire logic [TAG_W-1:0] op_tag,
   input wire logic [63:0] src1,
   input wire logic [63:0] src2,
   input wire logic [63:0] dp_result,
   input wire logic [2:0] dp_arith_flags,
   input wire logic dp_overflow,
   input wire logic dp_underflow,
   input wire logic dp_inexact,
   input wire logic dp_int_range,
   input wire logic dp_nonnum_fault,
   output logic res_valid,
   output logic [TAG_W-1:0] res_tag,
   output logic res_write,
   output logic [63:0] res_data,
   output logic arith_flags_write,
   output logic [2:0] arith_flags,
   output logic vec_fp_fault,
   output logic undefined_opcode_fault,
   output logic nonnum_fault
);

   logic [15:0] vec_fp_ctrl_stat_reg;
   logic os_vec_fault_support;
   logic [vec_fp_pkg::NUM_EXC-1:0] mask;

   fp_class_if a_cls ();
   fp_class_if b_cls ();

   fp_classify u_cls_a (
      .value(src1),
      .dbl(op_double),
      .cls(a_cls)
   );

   fp_classify u_cls_b (
      .value(src2),
      .dbl(op_double),
      .cls(b_cls)
   );

   function automatic logic [63:0] quiet_nan(input logic [63:0] v, input logic dbl);
      logic [63:0] q;
      q = v;
      if (dbl) begin
         q[vec_fp_pkg::QUIET_BIT_D] = 1'b1;
      end else begin
         q = {32'h00000000, v[31:0]};
         q[vec_fp_pkg::QUIET_BIT_S] = 1'b1;
      end
      return q;
   endfunction

   function automatic logic [63:0] indefinite(input logic dbl);
      logic [63:0] r;
      r = dbl ? vec_fp_pkg::QNAN_INDEF_D : {32'h00000000, vec_fp_pkg::QNAN_INDEF_S};
      return r;
   endfunction

   function automatic logic uses_two(input vec_fp_pkg::op_t k);
      logic r;
      case (k)
         vec_fp_pkg::OP_ADD, vec_fp_pkg::OP_SUB, vec_fp_pkg::OP_MUL, vec_fp_pkg::OP_DIV,
         vec_fp_pkg::OP_MAX, vec_fp_pkg::OP_MIN, vec_fp_pkg::OP_CMP, vec_fp_pkg::OP_COMI: r = 1'b1;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   assign mask = vec_fp_ctrl_stat_reg[vec_fp_pkg::MASK_LSB +: vec_fp_pkg::NUM_EXC];

   // operation classes
   logic fp_op;
   logic two_op;
   logic a_nan_any;
   logic b_nan_any;
   logic any_nan;
   logic any_snan;
   logic arith_op;

   always_comb begin
      case (op_kind)
         vec_fp_pkg::OP_NONE, vec_fp_pkg::OP_INT, vec_fp_pkg::OP_X87_TRUNC: fp_op = 1'b0;
         default: fp_op = 1'b1;
      endcase
   end

   assign two_op = uses_two(op_kind);
   assign a_nan_any = a_cls.nan;
   assign b_nan_any = two_op & b_cls.nan;
   assign any_nan = a_nan_any | b_nan_any;
   assign any_snan = a_cls.snan | (two_op & b_cls.snan);
   assign arith_op = (op_kind == vec_fp_pkg::OP_ADD) | (op_kind == vec_fp_pkg::OP_SUB) |
                     (op_kind == vec_fp_pkg::OP_MUL) | (op_kind == vec_fp_pkg::OP_DIV);

   // pre-computation: invalid operation
   logic inv;
   logic inf_combo;
   logic cmp_q_inv;
   logic [63:0] masked_val;

   assign cmp_q_inv = (op_pred == vec_fp_pkg::PRED_LT) | (op_pred == vec_fp_pkg::PRED_LE) |
                      (op_pred == vec_fp_pkg::PRED_NLT) | (op_pred == vec_fp_pkg::PRED_NLE);

   always_comb begin
      inf_combo = 1'b0;
      case (op_kind)
         vec_fp_pkg::OP_ADD: inf_combo = a_cls.inf & b_cls.inf & (a_cls.sign != b_cls.sign);
         vec_fp_pkg::OP_SUB: inf_combo = a_cls.inf & b_cls.inf & (a_cls.sign == b_cls.sign);
         vec_fp_pkg::OP_MUL: inf_combo = (a_cls.inf & b_cls.zero) | (a_cls.zero & b_cls.inf);
         vec_fp_pkg::OP_DIV: inf_combo = (a_cls.zero & b_cls.zero) | (a_cls.inf & b_cls.inf);
         vec_fp_pkg::OP_SQRT: inf_combo = a_cls.sign & ~a_cls.zero & ~a_cls.nan;
         default: inf_combo = 1'b0;
      endcase
   end

   always_comb begin
      inv = 1'b0;
      masked_val = dp_result;
      case (op_kind)
         vec_fp_pkg::OP_ADD, vec_fp_pkg::OP_SUB, vec_fp_pkg::OP_MUL, vec_fp_pkg::OP_DIV,
         vec_fp_pkg::OP_SQRT: begin
            if (any_snan) begin
               inv = 1'b1;
               // first signalling operand wins when both are signalling
               masked_val = quiet_nan(a_cls.snan ? src1 : src2, op_double);
            end else if (inf_combo & ~any_nan) begin
               inv = 1'b1;
               masked_val = indefinite(op_double);
            end
         end
         vec_fp_pkg::OP_MAX, vec_fp_pkg::OP_MIN: begin
            if (any_nan) begin
               inv = 1'b1;
               masked_val = src2;
            end
         end
         vec_fp_pkg::OP_CMP: begin
            if (any_nan) begin
               inv = any_snan | cmp_q_inv;
               case (op_pred)
                  vec_fp_pkg::PRED_UNORD, vec_fp_pkg::PRED_NEQ, vec_fp_pkg::PRED_NLT,
                  vec_fp_pkg::PRED_NLE: masked_val = op_double ? '1 : 64'h00000000FFFFFFFF;
                  default: masked_val = '0;
               endcase
            end
         end
         vec_fp_pkg::OP_COMI: begin
            inv = any_nan;
         end
         vec_fp_pkg::OP_CVT_FP: begin
            if (a_cls.snan) begin
               inv = 1'b1;
               // source precision is op_double, result is the other format
               if (op_double) begin
                  masked_val = {32'h00000000, src1[63], 8'hFF, 1'b1, src1[50:29]};
               end else begin
                  masked_val = {src1[31], 11'h7FF, 1'b1, src1[21:0], 29'h00000000};
               end
            end
         end
         vec_fp_pkg::OP_CVT_INT: begin
            if (a_cls.nan | a_cls.inf | dp_int_range) begin
               inv = 1'b1;
               masked_val = {32'h00000000, vec_fp_pkg::INT_INDEF};
            end
         end
         default: begin
            inv = 1'b0;
            masked_val = dp_result;
         end
      endcase
   end

   // pre-computation: denormal and divide-by-zero
   logic den;
   logic dz;
   logic [vec_fp_pkg::NUM_EXC-1:0] pre;
   logic [vec_fp_pkg::NUM_EXC-1:0] post;
   logic [vec_fp_pkg::NUM_EXC-1:0] exc;
   logic pre_stop;
   logic post_op;
   logic unmasked;

   assign den = fp_op & (op_kind != vec_fp_pkg::OP_CVT_INT) & (a_cls.denorm | (two_op & b_cls.denorm));
   assign dz = (op_kind == vec_fp_pkg::OP_DIV) & b_cls.zero & ~a_cls.zero & ~a_cls.inf & ~a_cls.nan;

   always_comb begin
      pre = '0;
      pre[vec_fp_pkg::INVALID_BIT] = fp_op & inv;
      pre[vec_fp_pkg::DENORMAL_BIT] = den;
      pre[vec_fp_pkg::DIV_ZERO_BIT] = fp_op & dz;
   end

   // post checks run only when every pre condition found was masked
   assign pre_stop = |(pre & ~mask);
   assign post_op = arith_op | (op_kind == vec_fp_pkg::OP_SQRT) | (op_kind == vec_fp_pkg::OP_CVT_FP) |
                    (op_kind == vec_fp_pkg::OP_CVT_INT);

   always_comb begin
      post = '0;
      if (post_op & ~pre_stop & ~inv) begin
         post[vec_fp_pkg::OVERFLOW_BIT] = dp_overflow;
         // masked underflow also needs the result to be inexact
         post[vec_fp_pkg::UNDERFLOW_BIT] = dp_underflow & (~mask[vec_fp_pkg::UNDERFLOW_BIT] | dp_inexact);
         post[vec_fp_pkg::INEXACT_BIT] = dp_inexact;
      end
   end

   // a non-numeric fault pre-empts all numeric reporting
   assign exc = (op_valid & ~dp_nonnum_fault) ? (pre | post) : '0;
   assign unmasked = |(exc & ~mask);

   // control/status register, set wins over a same-cycle software write
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         vec_fp_ctrl_stat_reg <= vec_fp_pkg::CSR_RESET;
      end else if (ce) begin
         if (reg_wr && reg_addr == vec_fp_pkg::ADDR_CTRL_STAT) begin
            vec_fp_ctrl_stat_reg <= (reg_wdata[15:0] & vec_fp_pkg::CSR_WMASK) | {10'h000, exc};
         end else begin
            vec_fp_ctrl_stat_reg <= vec_fp_ctrl_stat_reg | {10'h000, exc};
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         os_vec_fault_support <= vec_fp_pkg::CTRL4_RESET;
      end else if (ce && reg_wr && reg_addr == vec_fp_pkg::ADDR_CTRL4) begin
         os_vec_fault_support <= reg_wdata[vec_fp_pkg::OS_SUPPORT_BIT];
      end
   end

   // register read, one cycle after the strobe; unmapped reads as zero
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= '0;
      end else if (ce) begin
         if (reg_rd) begin
            case (reg_addr)
               vec_fp_pkg::ADDR_CTRL_STAT: reg_rdata <= {16'h0000, vec_fp_ctrl_stat_reg};
               vec_fp_pkg::ADDR_CTRL4: reg_rdata <= 32'(os_vec_fault_support) << vec_fp_pkg::OS_SUPPORT_BIT;
               default: reg_rdata <= '0;
            endcase
         end else begin
            reg_rdata <= '0;
         end
      end
   end

   // completion, one cycle after the instruction is presented
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         res_valid <= 1'b0;
         res_tag <= '0;
         nonnum_fault <= 1'b0;
      end else if (ce) begin
         res_valid <= op_valid;
         res_tag <= op_valid ? op_tag : res_tag;
         nonnum_fault <= op_valid & dp_nonnum_fault;
      end
   end

   // fault selection follows the os support bit at the moment of detection
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         vec_fp_fault <= 1'b0;
         undefined_opcode_fault <= 1'b0;
      end else if (ce) begin
         vec_fp_fault <= unmasked & os_vec_fault_support;
         undefined_opcode_fault <= unmasked & ~os_vec_fault_support;
      end
   end

   // destination write; any fault keeps the destination as it was
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         res_write <= 1'b0;
         res_data <= '0;
      end else if (ce) begin
         res_write <= op_valid & ~dp_nonnum_fault & ~unmasked & (op_kind != vec_fp_pkg::OP_COMI);
         if (op_valid) begin
            res_data <= (inv | (op_kind == vec_fp_pkg::OP_CMP)) ? masked_val : dp_result;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         arith_flags_write <= 1'b0;
         arith_flags <= '0;
      end else if (ce) begin
         arith_flags_write <= op_valid & ~dp_nonnum_fault & ~unmasked & (op_kind == vec_fp_pkg::OP_COMI);
         if (op_valid && op_kind == vec_fp_pkg::OP_COMI) begin
            arith_flags <= any_nan ? vec_fp_pkg::FLAGS_UNORDERED : dp_arith_flags;
         end
      end
   end

endmodule

// ==== simd_fp_exception_unit_properties.sv ====
// port-level checker for the vector floating-point exception unit
`timescale 1ns/1ns
module simd_fp_exception_unit_chk #(
   parameter int TAG_W = 6
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic op_valid,
   input wire vec_fp_pkg::op_t op_kind,
   input wire logic [TAG_W-1:0] op_tag,
   input wire logic dp_nonnum_fault,
   input wire logic res_valid,
   input wire logic [TAG_W-1:0] res_tag,
   input wire logic res_write,
   input wire logic vec_fp_fault,
   input wire logic undefined_opcode_fault,
   input wire logic nonnum_fault
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   property p_answer_next;
      ce && op_valid |-> ##1 res_valid;
   endproperty
   a_answer_next: assert property (p_answer_next) else $error("no result one cycle after op");

   property p_own_tag;
      ce && op_valid |=> res_tag == $past(op_tag);
   endproperty
   a_own_tag: assert property (p_own_tag) else $error("result tag not that of its op");

   property p_pulses_with_result;
      res_write || vec_fp_fault || undefined_opcode_fault || nonnum_fault |-> res_valid;
   endproperty
   a_pulses_with_result: assert property (p_pulses_with_result) else $error("pulse without result");

   property p_one_fault_kind;
      vec_fp_fault |-> !undefined_opcode_fault;
   endproperty
   a_one_fault_kind: assert property (p_one_fault_kind) else $error("both fault kinds at once");

   property p_fault_keeps_dest;
      vec_fp_fault || undefined_opcode_fault |-> !res_write;
   endproperty
   a_fault_keeps_dest: assert property (p_fault_keeps_dest) else $error("destination written on fault");

   property p_int_no_numeric;
      ce && op_valid && op_kind == vec_fp_pkg::OP_INT |=> !vec_fp_fault && !undefined_opcode_fault;
   endproperty
   a_int_no_numeric: assert property (p_int_no_numeric) else $error("numeric fault on integer op");

   property p_x87_no_vec;
      ce && op_valid && op_kind == vec_fp_pkg::OP_X87_TRUNC |=> !vec_fp_fault && !undefined_opcode_fault;
   endproperty
   a_x87_no_vec: assert property (p_x87_no_vec) else $error("vector fault on x87 store");

   property p_nonnum_pass;
      ce && op_valid && dp_nonnum_fault |=> nonnum_fault && !res_write && !vec_fp_fault;
   endproperty
   a_nonnum_pass: assert property (p_nonnum_pass) else $error("non-numeric fault not passed");

   property p_rdata_idle;
      $past(ce) && !$past(reg_rd) |-> reg_rdata == 32'h0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
endmodule

bind simd_fp_exception_unit simd_fp_exception_unit_chk #(.TAG_W(TAG_W)) chk_i (.clk(clk), .rstn(rstn), .ce(ce),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_valid(op_valid), .op_kind(op_kind), .op_tag(op_tag),
   .dp_nonnum_fault(dp_nonnum_fault), .res_valid(res_valid), .res_tag(res_tag), .res_write(res_write),
   .vec_fp_fault(vec_fp_fault), .undefined_opcode_fault(undefined_opcode_fault), .nonnum_fault(nonnum_fault));

// ==== exec_model.sv ====
// behavioural execution datapath feeding the exception unit
`timescale 1ns/1ns
module exec_model (
   input wire logic op_valid,
   input wire vec_fp_pkg::op_t op_kind,
   input wire logic [63:0] src1,
   input wire logic [2:0] post_ctl,
   input wire logic nonnum_ctl,
   output logic [63:0] dp_result,
   output logic [2:0] dp_arith_flags,
   output logic dp_overflow,
   output logic dp_underflow,
   output logic dp_inexact,
   output logic dp_int_range,
   output logic dp_nonnum_fault
);
   // result is a pass-through of the first source; outside a completing op it inverts, flags read 5, other levels go low, so stale data never helps
   assign dp_result = op_valid ? src1 : ~src1;
   assign dp_arith_flags = op_valid ? 3'h0 : 3'h5;
   assign dp_overflow = op_valid & post_ctl[0];
   assign dp_underflow = op_valid & post_ctl[1];
   assign dp_inexact = op_valid & post_ctl[2];
   assign dp_int_range = op_valid && op_kind == vec_fp_pkg::OP_CVT_INT && src1[62:52] == 11'h7FF;
   assign dp_nonnum_fault = op_valid & nonnum_ctl;
endmodule

// ==== simd_fp_exception_unit_test.sv ====
// self-checking testbench for the vector floating-point exception unit
`timescale 1ns/1ns
module simd_fp_exception_unit_test;
   localparam logic [63:0] INF = 64'h7FF0000000000000;
   localparam logic [63:0] NINF = 64'hFFF0000000000000;
   localparam logic [63:0] ONE = 64'h3FF0000000000000;
   localparam logic [63:0] SNAN = 64'h7FF0000000000001;
   localparam logic [63:0] QNAN = 64'h7FF8000000000000;
   localparam logic [63:0] IND = vec_fp_pkg::QNAN_INDEF_D;
   logic clk = 0, rstn = 0, ce = 1, reg_wr = 0, reg_rd = 0, op_valid = 0, op_double = 1, nonnum_ctl = 0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   vec_fp_pkg::op_t op_kind = vec_fp_pkg::OP_NONE;
   logic [2:0] op_pred = 3'h0, post_ctl = 3'h0, dp_arith_flags, arith_flags;
   logic [5:0] op_tag = 6'h00, res_tag;
   logic [63:0] src1 = 64'h0, src2 = 64'h0, dp_result, res_data;
   logic dp_overflow, dp_underflow, dp_inexact, dp_int_range, dp_nonnum_fault;
   logic res_valid, res_write, arith_flags_write, vec_fp_fault, undefined_opcode_fault, nonnum_fault;
   int err_count = 0, checks = 0;

   always #25 clk = ~clk;

   simd_fp_exception_unit #(.TAG_W(6)) uut (.clk(clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_valid(op_valid),
      .op_kind(op_kind), .op_double(op_double), .op_pred(op_pred), .op_tag(op_tag), .src1(src1), .src2(src2),
      .dp_result(dp_result), .dp_arith_flags(dp_arith_flags), .dp_overflow(dp_overflow),
      .dp_underflow(dp_underflow), .dp_inexact(dp_inexact), .dp_int_range(dp_int_range),
      .dp_nonnum_fault(dp_nonnum_fault), .res_valid(res_valid), .res_tag(res_tag), .res_write(res_write),
      .res_data(res_data), .arith_flags_write(arith_flags_write), .arith_flags(arith_flags),
      .vec_fp_fault(vec_fp_fault), .undefined_opcode_fault(undefined_opcode_fault), .nonnum_fault(nonnum_fault));

   exec_model partner (.op_valid(op_valid), .op_kind(op_kind), .src1(src1), .post_ctl(post_ctl),
      .nonnum_ctl(nonnum_ctl), .dp_result(dp_result), .dp_arith_flags(dp_arith_flags),
      .dp_overflow(dp_overflow), .dp_underflow(dp_underflow), .dp_inexact(dp_inexact),
      .dp_int_range(dp_int_range), .dp_nonnum_fault(dp_nonnum_fault));

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         err_count++;
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk({32'h0, reg_rdata}, {32'h0, exp});
   endtask

   // result pulses stand one cycle only, so they are sampled right after the answering edge
   task automatic op(input vec_fp_pkg::op_t k, input logic [2:0] pr, input logic [63:0] a, input logic [63:0] b,
                     input logic [2:0] post);
      logic [5:0] t;
      t = op_tag + 6'h01;
      @(posedge clk);
      op_valid <= 1'b1;
      op_kind <= k;
      op_pred <= pr;
      src1 <= a;
      src2 <= b;
      post_ctl <= post;
      op_tag <= t;
      @(posedge clk);
      op_valid <= 1'b0;
      post_ctl <= 3'h0;
      #1;
      chk({63'h0, res_valid}, 64'h1);
      chk({58'h0, res_tag}, {58'h0, t});
   endtask

   task automatic masked(input vec_fp_pkg::op_t k, input logic [2:0] pr, input logic [63:0] a, input logic [63:0] b,
                         input logic [63:0] exp);
      op(k, pr, a, b, 3'h0);
      chk({63'h0, res_write}, 64'h1);
      chk(res_data, exp);
   endtask

   task automatic fault(input vec_fp_pkg::op_t k, input logic [63:0] a, input logic [63:0] b, input logic vec);
      op(k, 3'h0, a, b, 3'h0);
      chk({61'h0, res_write, vec_fp_fault, undefined_opcode_fault}, {62'h0, vec, !vec});
   endtask

   task automatic t_registers;
      rd(4'h0, 32'h00001F80);
      rd(4'h4, 32'h0);
      wr(4'h0, 32'hFFFFFFFF);
      rd(4'h0, 32'h00001FBF);
      wr(4'h4, 32'hFFFFFFFF);
      rd(4'h4, 32'h00000400);
      wr(4'h8, 32'hFFFFFFFF);
      rd(4'h8, 32'h0);
      wr(4'h4, 32'h0);
      // a write strobe while the clock enable is low must leave the register alone
      @(posedge clk);
      ce <= 1'b0;
      reg_wr <= 1'b1;
      reg_addr <= 4'h4;
      reg_wdata <= 32'h00000400;
      @(posedge clk);
      ce <= 1'b1;
      reg_wr <= 1'b0;
      rd(4'h4, 32'h0);
   endtask

   task automatic t_masked_invalid;
      wr(4'h0, 32'h00001F80);
      masked(vec_fp_pkg::OP_SQRT, 3'h0, 64'h8000000000000000, ONE, 64'h8000000000000000);
      rd(4'h0, 32'h00001F80);
      masked(vec_fp_pkg::OP_ADD, 3'h0, INF, NINF, IND);
      rd(4'h0, 32'h00001F81);
      masked(vec_fp_pkg::OP_SUB, 3'h0, INF, INF, IND);
      masked(vec_fp_pkg::OP_MUL, 3'h0, INF, 64'h0, IND);
      masked(vec_fp_pkg::OP_DIV, 3'h0, 64'h0, 64'h0, IND);
      masked(vec_fp_pkg::OP_DIV, 3'h0, INF, INF, IND);
      masked(vec_fp_pkg::OP_ADD, 3'h0, SNAN, ONE, 64'h7FF8000000000001);
      masked(vec_fp_pkg::OP_SQRT, 3'h0, SNAN, ONE, 64'h7FF8000000000001);
      masked(vec_fp_pkg::OP_SQRT, 3'h0, 64'hBFF0000000000000, ONE, IND);
      masked(vec_fp_pkg::OP_MAX, 3'h0, QNAN, ONE, ONE);
      masked(vec_fp_pkg::OP_MIN, 3'h0, ONE, SNAN, SNAN);
      masked(vec_fp_pkg::OP_CVT_FP, 3'h0, SNAN, ONE, 64'h000000007FC00000);
      // single precision lanes live in the low word
      @(posedge clk);
      op_double <= 1'b0;
      masked(vec_fp_pkg::OP_CVT_FP, 3'h0, 64'h000000007F800001, ONE, 64'h7FF8000020000000);
      masked(vec_fp_pkg::OP_ADD, 3'h0, 64'h000000007F800000, 64'h00000000FF800000, 64'h00000000FFC00000);
      @(posedge clk);
      op_double <= 1'b1;
      for (int p = 0; p < 8; p++) begin
         masked(vec_fp_pkg::OP_CMP, 3'(p), QNAN, ONE, (p >= 3 && p <= 6) ? 64'hFFFFFFFFFFFFFFFF : 64'h0);
      end
      op(vec_fp_pkg::OP_CVT_INT, 3'h0, QNAN, ONE, 3'h0);
      chk({32'h0, res_data[31:0]}, {32'h0, vec_fp_pkg::INT_INDEF});
      op(vec_fp_pkg::OP_COMI, 3'h0, ONE, QNAN, 3'h0);
      chk({60'h0, arith_flags_write, arith_flags}, {60'h0, 1'b1, vec_fp_pkg::FLAGS_UNORDERED});
   endtask

   task automatic t_conditions;
      wr(4'h0, 32'h00001F80);
      op(vec_fp_pkg::OP_ADD, 3'h0, INF, NINF, 3'h1);
      rd(4'h0, 32'h00001F81);
      wr(4'h0, 32'h00001F80);
      op(vec_fp_pkg::OP_DIV, 3'h0, ONE, 64'h0, 3'h0);
      rd(4'h0, 32'h00001F84);
      wr(4'h0, 32'h00001F80);
      op(vec_fp_pkg::OP_ADD, 3'h0, ONE, ONE, 3'h5);
      rd(4'h0, 32'h00001FA8);
      wr(4'h0, 32'h00001F80);
      op(vec_fp_pkg::OP_MUL, 3'h0, ONE, ONE, 3'h2);
      rd(4'h0, 32'h00001F80);
      wr(4'h0, 32'h00001E80);
      wr(4'h4, 32'h00000400);
      fault(vec_fp_pkg::OP_ADD, 64'h0000000000000001, ONE, 1'b1);
      rd(4'h0, 32'h00001E82);
   endtask

   task automatic t_unmasked;
      wr(4'h0, 32'h00001F00);
      wr(4'h4, 32'h0);
      fault(vec_fp_pkg::OP_ADD, INF, NINF, 1'b0);
      wr(4'h4, 32'h00000400);
      fault(vec_fp_pkg::OP_SQRT, SNAN, ONE, 1'b1);
      rd(4'h0, 32'h00001F01);
      wr(4'h0, 32'h0);
      op(vec_fp_pkg::OP_INT, 3'h0, SNAN, INF, 3'h7);
      chk({62'h0, vec_fp_fault, undefined_opcode_fault}, 64'h0);
      op(vec_fp_pkg::OP_X87_TRUNC, 3'h0, SNAN, INF, 3'h7);
      chk({62'h0, vec_fp_fault, undefined_opcode_fault}, 64'h0);
      rd(4'h0, 32'h0);
      nonnum_ctl <= 1'b1;
      op(vec_fp_pkg::OP_ADD, 3'h0, INF, NINF, 3'h0);
      nonnum_ctl <= 1'b0;
      chk({61'h0, nonnum_fault, res_write, vec_fp_fault}, 64'h4);
   endtask

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      t_registers();
      t_masked_invalid();
      t_conditions();
      t_unmasked();
      wrap_up();
   end

   initial begin
      #1000000;
      err_count++;
      wrap_up();
   end
endmodule
